// ==== hdl/hwc_pkg.sv ====
// Purpose: Shared constants and types of the halt and wake-up controller.
// Assumes: One 40 MHz clock that keeps running through every halt mode.
// Notes:   Register offsets are byte addresses on an 8-bit register port.
package hwc_pkg;

  // Register map.
  localparam logic [7:0] PRESCALER_OFFSET   = 8'h49;
  localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h4a;
  localparam logic [7:0] PRESCALER_RESET    = 8'hff;
  localparam logic [7:0] CTRL_STATUS_RESET  = 8'h00;
  localparam logic [7:0] PRESCALER_FORBID   = 8'h00;

  // Control/status field positions.
  localparam int HALT_ENABLE_BIT = 0;
  localparam int MEASURE_BIT     = 1;
  localparam int FLAG_BIT        = 2;

  // Clock-select code that makes the reload timer keep the active halt.
  localparam logic [1:0] RELOAD_SEL_KEEP = 2'h1;

  // Timing.
  localparam int CLOCK_MHZ         = 40;
  localparam int STAB_SHORT_CYCLES = 256;
  localparam int STAB_LONG_CYCLES  = 4096;
  localparam int WAKE_FIXED_DIV    = 64;
  localparam logic [11:0] STAB_SHORT_LOAD = 12'(STAB_SHORT_CYCLES - 1);
  localparam logic [11:0] STAB_LONG_LOAD  = 12'(STAB_LONG_CYCLES - 1);
  localparam logic [5:0]  FIXED_DIV_LAST  = 6'(WAKE_FIXED_DIV - 1);

  // Power modes of the controller.
  typedef enum logic [5:0] {
    MODE_RUN     = 6'h01,
    MODE_ACTIVE  = 6'h02,
    MODE_AWU     = 6'h04,
    MODE_PLAIN   = 6'h08,
    MODE_STAB    = 6'h10,
    MODE_PLLWAIT = 6'h20
  } hwc_mode_t;

endpackage

// ==== hdl/hwc_timer_if.sv ====
// Purpose: Carries the wake-up timer controls between controller and timer.
// Assumes: Both ends run on the same clock.
// Notes:   The controller drives run, prescale and rcTick; the timer drives expire.
interface hwc_timer_if;
  logic       run;
  logic [7:0] prescale;
  logic       rcTick;
  logic       expire;

  modport ctrl  (output run, output prescale, output rcTick, input expire);
  modport timer (input run, input prescale, input rcTick, output expire);
endinterface

// ==== hdl/hwc_wakeup_timer.sv ====
// Purpose: Divides the wake-up RC ticks by a fixed 64 and then by the prescaler.
// Assumes: rcTick is a one-cycle pulse per RC period, prescale is never zero.
// Notes:   The first RC_STARTUP_TICKS ticks model the RC oscillator start-up.
module hwc_wakeup_timer #(
  parameter int RC_STARTUP_TICKS = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstN,
  // Timer controls.
  hwc_timer_if.timer tmr
);

  typedef struct packed {
    logic [3:0] startCount;
    logic [5:0] fine;
    logic [7:0] coarse;
    logic       expire;
  } hwc_timer_state_t;

  hwc_timer_state_t s_q;
  hwc_timer_state_t s_d;

  // Refuse a start-up count that the four-bit counter cannot hold.
  if (RC_STARTUP_TICKS < 0 || RC_STARTUP_TICKS > 15) begin : g_check
    $error("RC_STARTUP_TICKS must lie between 0 and 15.");
  end

  localparam logic [3:0] START_LAST = 4'(RC_STARTUP_TICKS);

  // Count RC ticks while running and clear everything when stopped.
  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    if (!tmr.run) begin
      s_d.startCount = 4'h0;
      s_d.fine = 6'h00;
      s_d.coarse = 8'h00;
    end else if (tmr.rcTick) begin
      if (s_q.startCount != START_LAST) begin
        s_d.startCount = s_q.startCount + 4'h1;
      end else if (s_q.fine != hwc_pkg::FIXED_DIV_LAST) begin
        s_d.fine = s_q.fine + 6'h01; // R9
      end else begin
        s_d.fine = 6'h00;
        if (s_q.coarse + 8'h01 == tmr.prescale) begin
          s_d.coarse = 8'h00;
          s_d.expire = 1'b1; // R9
        end else begin
          s_d.coarse = s_q.coarse + 8'h01;
        end
      end
    end
  end

  // Register the timer state.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tmr.expire = s_q.expire;

  // An expiry only follows a full fixed division while running.
  a_expire_after_div: assert property (@(posedge clock) disable iff (!rstN) // R9
    s_q.expire |-> $past(tmr.run) && $past(tmr.rcTick) && s_q.fine == 6'h00)
    else $error("Wake-up expiry without a completed division.");

endmodule

// ==== hdl/hwc_controller.sv ====
// Purpose: Halt mode decision, wake-up prescaler and wake-up sequencing.
// Assumes: clock runs in every mode; core and timer inputs are on clock.
// Notes:   Clock enables are decoded from the registered mode.
// How it works
// R1 - Halt enters active halt if timebase irq, or overflow irq with select 01.
// R2 - Reset out of active halt waits 256 or 4096 cycles, then fetches reset.
// R3 - Interrupt out of active halt resumes at once by servicing that interrupt.
// R4 - Entering active halt clears the interrupt mask bit.
// R5 - Active halt keeps only main oscillator and selected timer clocked.
// R6 - With active halt enabled, halt with watchdog active gives no reset.
// R7 - Active halt ends only on realtime base, halt-exit interrupts or reset.
// R8 - Halt with wake-up enable set enters auto wake-up halt with RC running.
// R9 - Wake-up delay is RC clock divided by 64 then by the prescaler.
// R10 - Expiry sets flag, raises irq, restarts oscillator, stabilises, services.
// R11 - Reading control/status clears the flag; writes to the flag do nothing.
// R12 - Measure bit enables RC oscillator and routes it to reload timer capture.
// R13 - Auto wake-up halt stops main oscillator and all peripheral clocks.
// R14 - Watchdog-in-halt option decides whether halt gives a watchdog reset.
// R15 - Auto wake-up halt ends on halt-exit irq or reset; entry clears mask.
// R16 - Prescaler divides by its value 1 to 255 and resets to ff.
// R17 - Writing zero to the prescaler leaves the value unchanged here.
// R18 - Wake-up enable changes only by software writes.
// R19 - With PLL enabled, add PLL start-up after the stabilisation delay.
// R20 - Plain halt only when active halt disabled and wake-up enable clear.
// R21 - A zero write to the prescaler is ignored.
// R22 - Control/status bits 7 to 3 read zero and ignore writes.
module hwc_controller #(
  parameter int PLL_STARTUP_NS   = 1000,
  parameter int RC_STARTUP_TICKS = 4
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       nrst,
  // Register port.
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // Core and timer status.
  input  wire logic       haltInstr,
  input  wire logic       liteTimebaseIrqEnable,
  input  wire logic       reloadOverflowIrqEnable,
  input  wire logic [1:0] reloadClockSelect,
  input  wire logic       realtimeBaseInterrupt,
  input  wire logic       haltExitIrq,
  input  wire logic       wakeResetReq,
  // Options and watchdog.
  input  wire logic       watchdogActive,
  input  wire logic       watchdogInHaltOption,
  input  wire logic       pllEnableOption,
  input  wire logic       stabLongSelect,
  // Wake-up RC oscillator.
  input  wire logic       wakeRcClockPin,
  output logic            rcOscEnable,
  output logic            rcCaptureOut,
  // Clock control.
  output logic            mainOscEnable,
  output logic            cpuClockEnable,
  output logic            periphClockEnable,
  output logic            timerClockEnable,
  // Core requests.
  output logic            clearIrqMask,
  output logic            serviceIrq,
  output logic            fetchResetVector,
  output logic            watchdogResetReq,
  output logic            wakeupIrq,
  output logic            haltActive
);

  localparam int PLL_CYCLES = (PLL_STARTUP_NS * hwc_pkg::CLOCK_MHZ + 999) / 1000;
  localparam logic [11:0] PLL_LOAD = 12'(PLL_CYCLES - 1);

  // Refuse a PLL start-up that the twelve-bit counter cannot serve.
  if (PLL_CYCLES < 1 || PLL_CYCLES > 4096) begin : g_check
    $error("PLL_STARTUP_NS gives a cycle count outside 1 to 4096.");
  end

  typedef struct packed {
    hwc_pkg::hwc_mode_t mode;
    logic [11:0]        count;
    logic               longStab;
    logic               wakeByReset;
    logic [7:0]         prescaler;
    logic               measure;
    logic               haltEnable;
    logic               flag;
    logic [7:0]         rdData;
    logic [2:0]         rcSync;
    logic               captureOut;
    logic               clearMask;
    logic               service;
    logic               fetchReset;
    logic               wdgReset;
  } hwc_ctrl_state_t;

  hwc_ctrl_state_t s_q;
  hwc_ctrl_state_t s_d;
  logic [1:0]      rstPipe_q;
  logic            rstN;
  logic            activeEnable;
  logic            haltWdgReset;
  logic            rcEdge;
  logic            inRun;
  logic            inActive;
  logic            inAwu;
  logic            inPlain;
  logic            inStab;

  hwc_timer_if tmr ();

  // Load value of the stabilisation counter for the selected delay.
  function automatic logic [11:0] stabLoad(input logic longSel);
    stabLoad = longSel ? hwc_pkg::STAB_LONG_LOAD : hwc_pkg::STAB_SHORT_LOAD;
  endfunction

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end

  assign rstN = rstPipe_q[1];

  // Halt decision terms and mode decode.
  assign activeEnable = liteTimebaseIrqEnable | (reloadOverflowIrqEnable // R1
                        & (reloadClockSelect == hwc_pkg::RELOAD_SEL_KEEP));
  assign haltWdgReset = watchdogActive & watchdogInHaltOption & ~activeEnable; // R6 R14
  assign rcEdge   = s_q.rcSync[1] & ~s_q.rcSync[2];
  assign inRun    = s_q.mode == hwc_pkg::MODE_RUN;
  assign inActive = s_q.mode == hwc_pkg::MODE_ACTIVE;
  assign inAwu    = s_q.mode == hwc_pkg::MODE_AWU;
  assign inPlain  = s_q.mode == hwc_pkg::MODE_PLAIN;
  assign inStab   = s_q.mode == hwc_pkg::MODE_STAB;

  // Next-state logic: register port, flag, synchroniser and mode sequence.
  always_comb begin
    s_d = s_q;
    s_d.clearMask = 1'b0;
    s_d.service = 1'b0;
    s_d.fetchReset = 1'b0;
    s_d.wdgReset = 1'b0;
    s_d.rdData = 8'h00;
    s_d.rcSync = {s_q.rcSync[1:0], wakeRcClockPin};
    s_d.captureOut = s_q.measure & s_q.rcSync[1]; // R12
    if (regWrite) begin
      if (regAddr == hwc_pkg::PRESCALER_OFFSET && regWrData != hwc_pkg::PRESCALER_FORBID) begin
        s_d.prescaler = regWrData; // R16 R17 R21
      end
      if (regAddr == hwc_pkg::CTRL_STATUS_OFFSET) begin
        s_d.measure = regWrData[hwc_pkg::MEASURE_BIT]; // R12 R22
        s_d.haltEnable = regWrData[hwc_pkg::HALT_ENABLE_BIT]; // R18
      end
    end
    if (regRead) begin
      if (regAddr == hwc_pkg::PRESCALER_OFFSET) begin
        s_d.rdData = s_q.prescaler;
      end else if (regAddr == hwc_pkg::CTRL_STATUS_OFFSET) begin
        s_d.rdData[hwc_pkg::FLAG_BIT] = s_q.flag; // R22
        s_d.rdData[hwc_pkg::MEASURE_BIT] = s_q.measure;
        s_d.rdData[hwc_pkg::HALT_ENABLE_BIT] = s_q.haltEnable;
        s_d.flag = 1'b0; // R11
      end
    end
    // A set in the clearing cycle wins over the read clear.
    if (tmr.expire) begin
      s_d.flag = 1'b1; // R10
    end
    case (s_q.mode)
      hwc_pkg::MODE_RUN: begin
        if (haltInstr) begin
          if (haltWdgReset) begin
            s_d.wdgReset = 1'b1; // R14
          end else begin
            s_d.clearMask = 1'b1; // R4 R15
            if (activeEnable) begin
              s_d.mode = hwc_pkg::MODE_ACTIVE; // R1
            end else if (s_q.haltEnable) begin
              s_d.mode = hwc_pkg::MODE_AWU; // R8
            end else begin
              s_d.mode = hwc_pkg::MODE_PLAIN; // R20
            end
          end
        end
      end
      hwc_pkg::MODE_ACTIVE: begin
        if (wakeResetReq) begin
          s_d.mode = hwc_pkg::MODE_STAB; // R2
          s_d.count = stabLoad(stabLongSelect);
          s_d.longStab = stabLongSelect;
          s_d.wakeByReset = 1'b1;
        end else if (realtimeBaseInterrupt || haltExitIrq) begin
          s_d.mode = hwc_pkg::MODE_RUN; // R3 R7
          s_d.service = 1'b1;
        end
      end
      hwc_pkg::MODE_AWU, hwc_pkg::MODE_PLAIN: begin
        if (wakeResetReq || haltExitIrq || (inAwu && tmr.expire)) begin
          s_d.mode = hwc_pkg::MODE_STAB; // R10 R15
          s_d.count = stabLoad(stabLongSelect);
          s_d.longStab = stabLongSelect;
          s_d.wakeByReset = wakeResetReq;
        end
      end
      hwc_pkg::MODE_STAB, hwc_pkg::MODE_PLLWAIT: begin
        if (s_q.count != 12'h000) begin
          s_d.count = s_q.count - 12'h001; // R2 R10
        end else if (inStab && pllEnableOption) begin
          s_d.mode = hwc_pkg::MODE_PLLWAIT; // R19
          s_d.count = PLL_LOAD;
        end else begin
          s_d.mode = hwc_pkg::MODE_RUN;
          s_d.fetchReset = s_q.wakeByReset; // R2
          s_d.service = ~s_q.wakeByReset; // R10
        end
      end
      default: begin
        s_d.mode = hwc_pkg::MODE_RUN;
      end
    endcase
  end

  // Register the controller state.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
      s_q.mode <= hwc_pkg::MODE_RUN;
      s_q.prescaler <= hwc_pkg::PRESCALER_RESET; // R16
      s_q.measure <= hwc_pkg::CTRL_STATUS_RESET[hwc_pkg::MEASURE_BIT];
      s_q.haltEnable <= hwc_pkg::CTRL_STATUS_RESET[hwc_pkg::HALT_ENABLE_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  // Wake-up divider fed with the synchronised RC edges.
  assign tmr.run = inAwu; // R8 R9
  assign tmr.prescale = s_q.prescaler;
  assign tmr.rcTick = rcEdge;

  hwc_wakeup_timer #(
    .RC_STARTUP_TICKS (RC_STARTUP_TICKS)
  ) u_timer (
    .clock (clock),
    .rstN  (rstN),
    .tmr   (tmr)
  );

  // Clock enables per mode.
  assign mainOscEnable     = ~(inAwu | inPlain); // R5 R13
  assign cpuClockEnable    = inRun;
  assign periphClockEnable = inRun; // R5 R13
  assign timerClockEnable  = inRun | inActive; // R5
  assign rcOscEnable       = s_q.measure | inAwu; // R8 R12

  // Registered outputs.
  assign regRdData        = s_q.rdData;
  assign rcCaptureOut     = s_q.captureOut;
  assign clearIrqMask     = s_q.clearMask;
  assign serviceIrq       = s_q.service;
  assign fetchResetVector = s_q.fetchReset;
  assign watchdogResetReq = s_q.wdgReset;
  assign wakeupIrq        = s_q.flag;
  assign haltActive       = ~inRun;

  a_active_entry: assert property (@(posedge clock) disable iff (!rstN) // R1
    inRun && haltInstr && activeEnable |=> inActive && clearIrqMask && !watchdogResetReq)
    else $error("Halt with active halt enabled did not enter active halt.");

  a_short_stab_len: assert property (@(posedge clock) disable iff (!rstN) // R2
    $rose(inStab) && !s_q.longStab && !pllEnableOption |-> ##255 inStab ##1 !inStab)
    else $error("Short stabilisation delay is not 256 cycles.");

  a_active_irq_exit: assert property (@(posedge clock) disable iff (!rstN) // R3
    inActive && !wakeResetReq && (realtimeBaseInterrupt || haltExitIrq)
    |=> inRun && serviceIrq && !fetchResetVector)
    else $error("Interrupt did not end active halt at once.");

  a_active_clocks: assert property (@(posedge clock) disable iff (!rstN) // R5
    inActive |-> mainOscEnable && timerClockEnable && !periphClockEnable && !cpuClockEnable)
    else $error("Wrong clocks in active halt.");

  a_awu_entry: assert property (@(posedge clock) disable iff (!rstN) // R8
    inRun && haltInstr && !activeEnable && s_q.haltEnable && !haltWdgReset
    |=> inAwu && rcOscEnable && !mainOscEnable)
    else $error("Halt with wake-up enable did not enter auto wake-up halt.");

  a_expiry_flag: assert property (@(posedge clock) disable iff (!rstN) // R10
    inAwu && tmr.expire && !wakeResetReq |=> wakeupIrq && inStab && mainOscEnable)
    else $error("Wake-up expiry did not set flag and restart oscillator.");

  a_flag_read_clear: assert property (@(posedge clock) disable iff (!rstN) // R11
    regRead && regAddr == hwc_pkg::CTRL_STATUS_OFFSET && !tmr.expire |=> !wakeupIrq)
    else $error("Reading control/status did not clear the flag.");

  a_flag_write_keep: assert property (@(posedge clock) disable iff (!rstN) // R11
    regWrite && regAddr == hwc_pkg::CTRL_STATUS_OFFSET
    |=> wakeupIrq == ($past(wakeupIrq) || $past(tmr.expire)))
    else $error("Write changed the wake-up flag.");

  a_zero_write_keep: assert property (@(posedge clock) disable iff (!rstN) // R21
    regWrite && regAddr == hwc_pkg::PRESCALER_OFFSET && regWrData == 8'h00
    |=> $stable(s_q.prescaler))
    else $error("Zero write changed the prescaler.");

  a_plain_entry: assert property (@(posedge clock) disable iff (!rstN) // R20
    inRun && haltInstr && !activeEnable && !s_q.haltEnable && !haltWdgReset |=> inPlain)
    else $error("Halt did not enter plain halt.");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rstN) // R22
    $past(regRead) && $past(regAddr) == hwc_pkg::CTRL_STATUS_OFFSET |-> regRdData[7:3] == 5'h00)
    else $error("Reserved control/status bits read non-zero.");

  a_wdg_halt_reset: assert property (@(posedge clock) disable iff (!rstN) // R14
    inRun && haltInstr && watchdogActive && watchdogInHaltOption && !liteTimebaseIrqEnable
    && !reloadOverflowIrqEnable |=> inRun && watchdogResetReq && !clearIrqMask)
    else $error("Halt with the watchdog option did not give a watchdog reset.");

  a_active_no_wdg: assert property (@(posedge clock) disable iff (!rstN) // R6
    inRun && haltInstr && liteTimebaseIrqEnable |=> inActive && !watchdogResetReq)
    else $error("Halt with active halt enabled gave a watchdog reset.");

  a_reset_wake_stab: assert property (@(posedge clock) disable iff (!rstN) // R2
    inActive && wakeResetReq |=> inStab && !serviceIrq && !fetchResetVector)
    else $error("Reset in active halt did not start the stabilisation delay.");

  a_pll_wait_entry: assert property (@(posedge clock) disable iff (!rstN) // R19
    inStab && s_q.count == 12'h000 && pllEnableOption
    |=> s_q.mode == hwc_pkg::MODE_PLLWAIT && s_q.count == PLL_LOAD && !serviceIrq)
    else $error("PLL start-up wait did not follow the stabilisation delay.");

  a_enable_sw_only: assert property (@(posedge clock) disable iff (!rstN) // R18
    !(regWrite && regAddr == hwc_pkg::CTRL_STATUS_OFFSET) |=> $stable(s_q.haltEnable))
    else $error("Wake-up enable changed without a software write.");

  a_halt_irq_exit: assert property (@(posedge clock) disable iff (!rstN) // R15
    (inAwu || inPlain) && haltExitIrq |=> inStab && !serviceIrq)
    else $error("Halt-exit interrupt did not start the stabilisation delay.");

  a_capture_route: assert property (@(posedge clock) disable iff (!rstN) // R12
    s_q.measure |-> rcOscEnable ##1 (rcCaptureOut == $past(s_q.rcSync[1])))
    else $error("Measurement did not route the RC clock to the capture output.");

endmodule

// ==== testbench/halt_wakeup_controller_test.sv ====
// Purpose: Self-checking bench for the halt and wake-up controller.
// Assumes: One 40 MHz clock; short PLL wait and no RC start-up ticks.
// Notes:   Register and halt cases run from tables; wake timing is hand tested.
module halt_wakeup_controller_test;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] wd; logic [7:0] rd;} hwc_reg_row_t;
  typedef struct packed {logic lite; logic ovf; logic [1:0] sel; logic wdA; logic wdO;
                         logic awu; logic [1:0] kind;} hwc_halt_row_t;

  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdData;
  logic       haltInstr = 1'b0;
  logic       lite = 1'b0;
  logic       ovf = 1'b0;
  logic [1:0] sel = 2'h0;
  logic       rtIrq = 1'b0;
  logic       exitIrq = 1'b0;
  logic       wakeRst = 1'b0;
  logic       wdA = 1'b0;
  logic       wdO = 1'b0;
  logic       longSel = 1'b0;
  logic       pll = 1'b1;
  logic       rcPin = 1'b0;
  logic       rcRun = 1'b0;
  logic [1:0] rcDiv = 2'h0;
  int         rcEdges = 0;
  logic       rcOscEnable, rcCaptureOut, mainOscEnable, cpuClockEnable;
  logic       periphClockEnable, timerClockEnable, clearIrqMask, serviceIrq;
  logic       fetchResetVector, watchdogResetReq, wakeupIrq, haltActive;
  int         errorCnt = 0;
  int         checks = 0;
  int         n, k;
  // A 25 ns PLL start-up is one 40 MHz clock.
  localparam int PLL_WAIT = 1;

  // Register cases: optional write, then a read of the same address.
  hwc_reg_row_t regRows [7] = '{
    '{1'b0, 8'h49, 8'h00, 8'hff}, '{1'b0, 8'h4a, 8'h00, 8'h00},
    '{1'b1, 8'h49, 8'h10, 8'h10}, '{1'b1, 8'h49, 8'h00, 8'h10},
    '{1'b1, 8'h4a, 8'hff, 8'h03}, '{1'b1, 8'h4a, 8'h00, 8'h00},
    '{1'b1, 8'h50, 8'h5a, 8'h00}};
  // Halt cases; kind 0 active, 1 plain, 2 auto wake-up, 3 watchdog reset.
  hwc_halt_row_t haltRows [7] = '{
    '{1'b1, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0, 2'h0}, '{1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 2'h0},
    '{1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 2'h1}, '{1'b0, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0, 2'h3},
    '{1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 2'h1}, '{1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 2'h2},
    '{1'b1, 1'b0, 2'h3, 1'b0, 1'b0, 1'b1, 2'h0}};

  hwc_controller #(.PLL_STARTUP_NS(25), .RC_STARTUP_TICKS(0)) u_dut (
    .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .haltInstr(haltInstr),
    .liteTimebaseIrqEnable(lite), .reloadOverflowIrqEnable(ovf), .reloadClockSelect(sel),
    .realtimeBaseInterrupt(rtIrq), .haltExitIrq(exitIrq), .wakeResetReq(wakeRst),
    .watchdogActive(wdA), .watchdogInHaltOption(wdO), .pllEnableOption(pll),
    .stabLongSelect(longSel), .wakeRcClockPin(rcPin), .rcOscEnable(rcOscEnable),
    .rcCaptureOut(rcCaptureOut), .mainOscEnable(mainOscEnable),
    .cpuClockEnable(cpuClockEnable), .periphClockEnable(periphClockEnable),
    .timerClockEnable(timerClockEnable), .clearIrqMask(clearIrqMask),
    .serviceIrq(serviceIrq), .fetchResetVector(fetchResetVector),
    .watchdogResetReq(watchdogResetReq), .wakeupIrq(wakeupIrq), .haltActive(haltActive));

  // Clock of 25 ns period.
  always #12.5 clock = ~clock;

  // RC pin toggles every two clocks while running; rising edges are counted from each halt.
  always @(posedge clock) begin
    rcDiv <= rcDiv + 2'h1;
    if (rcRun && rcDiv[0]) begin
      rcPin <= ~rcPin;
    end
    if (haltInstr) begin
      rcEdges <= 0;
    end else if (rcRun && rcDiv[0] && !rcPin) begin
      rcEdges <= rcEdges + 1;
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // One-cycle register read; the data are sampled in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Pulses the halt instruction and leaves time just after the taking edge.
  task automatic halt();
    @(posedge clock);
    haltInstr <= 1'b1;
    @(posedge clock);
    haltInstr <= 1'b0;
    #1;
  endtask

  // Counts edges until the chosen output is high, bounded; a pulse launched at the
  // edge of the call is seen with a count of zero.
  task automatic wait_evt(input int which, output int cnt);
    logic hit;
    cnt = 0;
    #1;
    hit = (which == 0) ? serviceIrq : (which == 1) ? fetchResetVector : wakeupIrq;
    while (hit !== 1'b1 && cnt < 6000) begin
      @(posedge clock);
      #1;
      cnt++;
      hit = (which == 0) ? serviceIrq : (which == 1) ? fetchResetVector : wakeupIrq;
    end
  endtask

  // Counts the cycles, out of 40, in which the capture output is high.
  task automatic count_capture(output int c);
    c = 0;
    repeat (40) begin
      @(posedge clock);
      #1;
      c += (rcCaptureOut === 1'b1);
    end
  endtask

  // Main sequence.
  initial begin
    logic [7:0] d;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("haltActive", 8'h00, {7'h0, haltActive});
    chk("mainOsc", 8'h01, {7'h0, mainOscEnable});
    // Register table.
    foreach (regRows[i]) begin
      if (regRows[i].wr) wr(regRows[i].addr, regRows[i].wd);
      rd(regRows[i].addr, d);
      chk("regRdData", regRows[i].rd, d);
    end
    // Halt decision table, each halt case followed by its exit; the watchdog reset case stays in run.
    foreach (haltRows[i]) begin
      @(posedge clock);
      k = haltRows[i].kind;
      lite <= haltRows[i].lite;
      ovf <= haltRows[i].ovf;
      sel <= haltRows[i].sel;
      wdA <= haltRows[i].wdA;
      wdO <= haltRows[i].wdO;
      wr(8'h4a, {7'h0, haltRows[i].awu});
      halt();
      chk("haltActive", {7'h0, k != 3}, {7'h0, haltActive});
      chk("clearIrqMask", {7'h0, k != 3}, {7'h0, clearIrqMask});
      chk("watchdogReset", {7'h0, k == 3}, {7'h0, watchdogResetReq});
      chk("mainOsc", {7'h0, k == 0 || k == 3}, {7'h0, mainOscEnable});
      chk("timerClock", {7'h0, k == 0 || k == 3}, {7'h0, timerClockEnable});
      chk("periphClock", {7'h0, k == 3}, {7'h0, periphClockEnable});
      chk("cpuClock", {7'h0, k == 3}, {7'h0, cpuClockEnable});
      chk("rcOsc", {7'h0, k == 2}, {7'h0, rcOscEnable});
      if (k == 0) begin
        @(posedge clock) rtIrq <= 1'b1;
        @(posedge clock) rtIrq <= 1'b0;
        wait_evt(0, n);
        chk("activeExitFast", 8'h01, {7'h0, n == 0});
      end else if (k != 3) begin
        @(posedge clock) exitIrq <= 1'b1;
        @(posedge clock) exitIrq <= 1'b0;
        wait_evt(0, n);
        chk("haltExitStab", 8'h01, {7'h0, n == hwc_pkg::STAB_SHORT_CYCLES + PLL_WAIT});
      end
      chk("backToRun", 8'h00, {7'h0, haltActive});
    end
    @(posedge clock);
    lite <= 1'b0;
    ovf <= 1'b0;
    wdA <= 1'b0;
    pll <= 1'b0;
    // Auto wake-up by expiry with prescaler 2.
    wr(8'h49, 8'h02);
    wr(8'h4a, 8'h01);
    halt();
    rcRun <= 1'b1;
    wait_evt(2, n);
    chk("rcEdgesToFlag", 8'h01, {7'h0, rcEdges >= 128 && rcEdges <= 130});
    chk("mainOscRestart", 8'h01, {7'h0, mainOscEnable});
    wait_evt(0, n);
    chk("wakeStab", 8'h01, {7'h0, n == hwc_pkg::STAB_SHORT_CYCLES});
    rcRun <= 1'b0;
    rd(8'h4a, d);
    chk("ctrlFlagSet", 8'h05, d);
    chk("wakeupIrqClr", 8'h00, {7'h0, wakeupIrq});
    rd(8'h4a, d);
    chk("ctrlFlagClr", 8'h01, d);
    // Reset out of active halt with the long delay.
    wr(8'h4a, 8'h00);
    longSel <= 1'b1;
    pll <= 1'b1;
    lite <= 1'b1;
    halt();
    @(posedge clock) wakeRst <= 1'b1;
    @(posedge clock) wakeRst <= 1'b0;
    wait_evt(1, n);
    chk("resetStab", 8'h01, {7'h0, n == hwc_pkg::STAB_LONG_CYCLES + PLL_WAIT});
    @(posedge clock) lite <= 1'b0;
    // Measurement routes the RC pin to the capture output only while enabled.
    wr(8'h4a, 8'h02);
    #1;
    chk("rcOscMeasure", 8'h01, {7'h0, rcOscEnable});
    rcRun <= 1'b1;
    count_capture(k);
    chk("captureToggles", 8'h01, {7'h0, k >= 14 && k <= 24});
    wr(8'h4a, 8'h00);
    repeat (6) @(posedge clock);
    count_capture(k);
    chk("captureIdle", 8'h00, {7'h0, k > 0});
    rcRun <= 1'b0;
    giveVerdict();
  end

  // Watchdog for a hung run, well beyond the expected 5800 cycles.
  initial begin
    #500000;
    errorCnt++;
    giveVerdict();
  end
endmodule
